// File: rtl/sadc_consts.svh
// register indices, field positions, reset values and timing counts of the converter control
//
// Notes on behaviour
// RL1 - analog power enable clears on reset; no conversion runs until software sets it.
// RL2 - software waits the analog warm-up time after enabling power before starting.
// RL3 - result is an unsigned 10-bit code, 1024 steps between the reference levels.
// RL4 - one bit trialled per converter clock, bit 9 to bit 0; kept if DAC below input.
// RL5 - converter clock period is machine clock period times prescale setting plus one.
// RL6 - machine clock is oscillator period times 4, 64 or 1024 per divider select.
// RL7 - software keeps the converter clock period between 1 and 6.25 microseconds.
// RL8 - conversion lasts 16 converter clocks: 5 sampling, 10 trials; done flag on last.
// RL9 - with external start enabled, a falling pin edge starts a conversion too.
// RL10 - any start drives the start/busy flag to 1 for the whole conversion.
// RL11 - a started conversion completes unless power enable is cleared.
// RL12 - interrupt on done, or only on done with window match when qualified.
// RL13 - software clears the done flag after reading the result to drop the interrupt.
// RL14 - software sets converter interrupt enable, bit 1 of the extended enable register.
// RL15 - software programs channel, mode, window and prescale before starting.
// RL16 - continuous mode restarts on the next machine cycle; busy stays set.
// RL17 - selecting single shot mid-run finishes the current conversion, then halts.
// RL18 - window compares upper 8 result bits with two 8-bit limits.
// RL19 - match equals outside select xor (upper < bits) xor (lower < bits), unsigned.
// RL20 - both limits are treated alike; no ordering check between them.
// RL21 - clearing power enable aborts any conversion and clears start/busy.
// RL22 - high byte is bits 9..2, or bits 9,8 right aligned; low byte is bits 7..0.
// RL23 - start on busy written 0 to 1; writes of 0 ignored while busy; hardware clears.
// RL24 - 3-bit channel select is applied when the next conversion starts.
// RL25 - external start pin synchronised; fall is a high sample then a low sample.
`ifndef SADC_CONSTS_SVH
`define SADC_CONSTS_SVH

// register indices; byte address is four times the index
`define SADC_IDX_CTRL1   8'hB2
`define SADC_IDX_CTRL2   8'hB3
`define SADC_IDX_RES_HI  8'hB4
`define SADC_IDX_RES_LO  8'hB5
`define SADC_IDX_WIN_UP  8'hB6
`define SADC_IDX_WIN_LO  8'hB7
`define SADC_IDX_PWRMGT  8'hB8
`define SADC_IDX_EXT_IE  8'hB9

// control register 1 fields
`define SADC_B_BUSY      7
`define SADC_B_EOC       6
`define SADC_B_CONT      5
`define SADC_B_EXT       4
`define SADC_B_QUAL      3
`define SADC_B_MATCH     2
`define SADC_B_PWR       1
`define SADC_B_OUTSIDE   0
// control register 2 fields
`define SADC_B_FMT       7
`define SADC_F_MUX       6:4
`define SADC_F_PSC       3:0
// own registers
`define SADC_B_CONV_IE   1
`define SADC_F_CDIV      1:0

`define SADC_RST_BYTE    8'h00
`define SADC_RST_WORD    32'h0000_0000

// sequencer counts in converter clocks
`define SADC_SAMPLE_LAST 4'h4
`define SADC_TRIAL_FIRST 4'h5
`define SADC_CONV_LAST   4'hF
`define SADC_SAR_MSB     10'h200

// machine clock dividers in oscillator cycles
`define SADC_MDIV_4      11'h004
`define SADC_MDIV_64     11'h040
`define SADC_MDIV_1024   11'h400

`endif

// File: rtl/sadc_pkg.sv
// types shared by the converter control modules
package sadc_pkg;

  typedef enum logic [2:0] {
    SADC_IDLE   = 3'h1,
    SADC_SAMPLE = 3'h2,
    SADC_TRIAL  = 3'h4
  } sadc_state_t;

  typedef enum logic [1:0] {
    SADC_DIV_4    = 2'h0,
    SADC_DIV_64   = 2'h1,
    SADC_DIV_1024 = 2'h2,
    SADC_DIV_ALT  = 2'h3
  } sadc_div_t;

endpackage

// File: rtl/sadc_prescaler.sv
// machine clock and converter clock tick generator
`timescale 1ns/1ps
`include "sadc_consts.svh"
module sadc_prescaler #(
  parameter int PSC_W = 4
) (
  input  wire logic             clk,
  input  wire logic             arst_n,
  input  wire logic [1:0]       div_sel,
  input  wire logic [PSC_W-1:0] psc,
  input  wire logic             restart,
  output logic                  mclk_tick,
  output logic                  aclk_tick
);
  logic [10:0]      mcnt_r;
  logic [PSC_W-1:0] acnt_r;
  logic [10:0]      div_last;

  // unused select code falls back to the slowest divider
  assign div_last  = (div_sel == sadc_pkg::SADC_DIV_4)  ? 11'(`SADC_MDIV_4 - 11'h001) :  // RL6
                     (div_sel == sadc_pkg::SADC_DIV_64) ? 11'(`SADC_MDIV_64 - 11'h001) :
                                                          11'(`SADC_MDIV_1024 - 11'h001);
  assign mclk_tick = (mcnt_r >= div_last);
  assign aclk_tick = mclk_tick & (acnt_r >= psc);  // RL5

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mcnt_r <= 11'h000;
      acnt_r <= '0;
    end else if (restart || mclk_tick) begin
      mcnt_r <= 11'h000;
      acnt_r <= (restart || aclk_tick) ? '0 : PSC_W'(acnt_r + 1'b1);
    end else begin
      mcnt_r <= 11'(mcnt_r + 11'h001);
    end
  end

endmodule // sadc_prescaler

// File: rtl/sadc_window.sv
// window comparator on the upper result bits
`timescale 1ns/1ps
module sadc_window #(
  parameter int W = 8
) (
  input  wire logic [W-1:0] upper,
  input  wire logic [W-1:0] lower,
  input  wire logic [W-1:0] value,
  input  wire logic         outside,
  output logic              match
);
  // limits are not ordered; swapped limits just follow the same equation
  assign match = outside ^ (upper < value) ^ (lower < value);  // RL19 RL20

endmodule // sadc_window

// File: rtl/sadc_top.sv
// converter control: wishbone registers, sequencer, bit trials and window qualifier
`timescale 1ns/1ps
`include "sadc_consts.svh"
module sadc_top (
  input  wire logic        CLK,
  input  wire logic        ARST_N,
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [31:0] WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O,
  input  wire logic        EXT_START,
  input  wire logic        COMP_DAC_BELOW,
  output logic             ANALOG_POWER,
  output logic             SAMPLE_HOLD,
  output logic      [9:0]  DAC_CODE,
  output logic      [2:0]  CHANNEL,
  output logic             IRQ
);
  function automatic logic reg_hit(input logic [31:0] adr, input logic [7:0] idx);
    return (adr[31:10] == 22'h00_0000) && (adr[1:0] == 2'h0) && (adr[9:2] == idx);
  endfunction

  // bus
  logic                  ack_r;
  logic [31:0]           dat_r;
  logic                  wb_req;
  logic                  wr_en;
  logic [7:0]            wd;
  logic                  wr_c1, wr_c2, wr_wu, wr_wl, wr_pm, wr_ie;
  logic [7:0]            rd_byte;
  // control and status
  logic                  busy_r, eoc_r, cont_r, ext_en_r;
  logic                  qual_en_r, match_r, pwr_r, outside_r;
  logic                  fmt_r;
  logic [2:0]            mux_r;
  logic [3:0]            psc_r;
  logic [7:0]            win_up_r;
  logic [7:0]            win_lo_r;
  logic [1:0]            cdiv_r;
  logic                  conv_ie_r;
  logic [9:0]            result_r;
  logic                  qual_r;
  logic                  irq_r;
  logic [7:0]            ctrl1_rd;
  logic [7:0]            res_hi_rd;
  // sequencer
  sadc_pkg::sadc_state_t state_r;
  logic [3:0]            cnt_r;
  logic [9:0]            sar_r;
  logic                  sh_r;
  logic [2:0]            chan_r;
  logic                  restart_r;
  logic [9:0]            trial_mask;
  logic [9:0]            sar_trial;
  logic                  pwr_nxt, cont_nxt, busy_nxt;
  logic                  sw_start, ext_start, auto_start, go, abort, done, eoc_clr;
  logic                  win_match;
  logic                  mclk_tick;
  logic                  aclk_tick;
  // external start pin
  logic                  ext_s1_r, ext_s2_r, ext_s3_r;
  logic                  ext_fall;

  // register bus decode
  assign wb_req = WB_CYC_I & WB_STB_I;
  assign wr_en  = wb_req & WB_WE_I & ack_r & WB_SEL_I[0];
  assign wd     = WB_DAT_I[7:0];
  assign wr_c1  = wr_en & reg_hit(WB_ADR_I, `SADC_IDX_CTRL1);
  assign wr_c2  = wr_en & reg_hit(WB_ADR_I, `SADC_IDX_CTRL2);
  assign wr_wu  = wr_en & reg_hit(WB_ADR_I, `SADC_IDX_WIN_UP);
  assign wr_wl  = wr_en & reg_hit(WB_ADR_I, `SADC_IDX_WIN_LO);
  assign wr_pm  = wr_en & reg_hit(WB_ADR_I, `SADC_IDX_PWRMGT);
  assign wr_ie  = wr_en & reg_hit(WB_ADR_I, `SADC_IDX_EXT_IE);

  assign ctrl1_rd  = {busy_r, eoc_r, cont_r, ext_en_r, qual_en_r, match_r, pwr_r, outside_r};
  assign res_hi_rd = fmt_r ? {6'h00, result_r[9:8]} : result_r[9:2];  // RL22
  assign rd_byte   =
    reg_hit(WB_ADR_I, `SADC_IDX_CTRL1)  ? ctrl1_rd :
    reg_hit(WB_ADR_I, `SADC_IDX_CTRL2)  ? {fmt_r, mux_r, psc_r} :
    reg_hit(WB_ADR_I, `SADC_IDX_RES_HI) ? res_hi_rd :
    reg_hit(WB_ADR_I, `SADC_IDX_RES_LO) ? result_r[7:0] :  // RL22
    reg_hit(WB_ADR_I, `SADC_IDX_WIN_UP) ? win_up_r :
    reg_hit(WB_ADR_I, `SADC_IDX_WIN_LO) ? win_lo_r :
    reg_hit(WB_ADR_I, `SADC_IDX_PWRMGT) ? {6'h00, cdiv_r} :
    reg_hit(WB_ADR_I, `SADC_IDX_EXT_IE) ? {6'h00, conv_ie_r, 1'b0} :
                                          `SADC_RST_BYTE;

  // every access, mapped or not, is acked one cycle after it is raised
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ack_r <= 1'b0;
      dat_r <= `SADC_RST_WORD;
    end else begin
      ack_r <= wb_req & ~ack_r;
      dat_r <= (wb_req & ~ack_r & ~WB_WE_I) ? {24'h00_0000, rd_byte} : `SADC_RST_WORD;
    end
  end

  // start, abort and completion conditions
  assign pwr_nxt    = wr_c1 ? wd[`SADC_B_PWR] : pwr_r;
  assign cont_nxt   = wr_c1 ? wd[`SADC_B_CONT] : cont_r;
  assign abort      = ~pwr_nxt;  // RL1 RL11 RL21
  assign sw_start   = wr_c1 & wd[`SADC_B_BUSY] & ~busy_r;  // RL23
  assign ext_start  = ext_fall & ext_en_r & ~busy_r;  // RL9
  assign auto_start = restart_r & mclk_tick & cont_nxt;  // RL16
  assign go         = (sw_start | ext_start | auto_start) & ~abort;
  assign done       = aclk_tick & (state_r == sadc_pkg::SADC_TRIAL)
                      & (cnt_r == `SADC_CONV_LAST) & ~abort;  // RL8
  assign eoc_clr    = wr_c1 & ~wd[`SADC_B_EOC];
  // a 0 written to busy has no path here; only hardware clears it
  assign busy_nxt   = abort ? 1'b0 :  // RL21
                      go ? 1'b1 :  // RL10
                      done ? cont_nxt :  // RL16 RL17
                      (restart_r & ~cont_nxt) ? 1'b0 :  // RL17
                      busy_r;  // RL23

  // external start: two-stage sync, third stage only for edge detect
  assign ext_fall = ext_s3_r & ~ext_s2_r;  // RL25
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ext_s1_r <= 1'b1;
      ext_s2_r <= 1'b1;
      ext_s3_r <= 1'b1;
    end else begin
      ext_s1_r <= EXT_START;  // RL25
      ext_s2_r <= ext_s1_r;
      ext_s3_r <= ext_s2_r;
    end
  end

  sadc_prescaler #(
    .PSC_W     (4)
  ) u_presc (
    .clk       (CLK),
    .arst_n    (ARST_N),
    .div_sel   (cdiv_r),
    .psc       (psc_r),
    .restart   (go),
    .mclk_tick (mclk_tick),
    .aclk_tick (aclk_tick)
  );

  sadc_window #(
    .W       (8)
  ) u_window (
    .upper   (win_up_r),
    .lower   (win_lo_r),
    .value   (sar_r[9:2]),
    .outside (outside_r),
    .match   (win_match)
  );  // RL18

  // bit trial: keep the tried bit when the DAC sits below the held input
  assign trial_mask = `SADC_SAR_MSB >> 4'(cnt_r - `SADC_TRIAL_FIRST);
  assign sar_trial  = (COMP_DAC_BELOW ? sar_r : (sar_r & ~trial_mask))
                      | (trial_mask >> 1);  // RL4

  // control registers
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      {cont_r, ext_en_r, qual_en_r, pwr_r, outside_r} <= 5'h00;  // RL1
      {fmt_r, mux_r, psc_r}                           <= `SADC_RST_BYTE;
      win_up_r  <= `SADC_RST_BYTE;
      win_lo_r  <= `SADC_RST_BYTE;
      cdiv_r    <= 2'h0;
      conv_ie_r <= 1'b0;
      busy_r    <= 1'b0;
    end else begin
      if (wr_c1) begin
        cont_r    <= wd[`SADC_B_CONT];
        ext_en_r  <= wd[`SADC_B_EXT];
        qual_en_r <= wd[`SADC_B_QUAL];
        pwr_r     <= wd[`SADC_B_PWR];
        outside_r <= wd[`SADC_B_OUTSIDE];
      end
      if (wr_c2) begin
        {fmt_r, mux_r, psc_r} <= wd;
      end
      if (wr_wu) begin
        win_up_r <= wd;
      end
      if (wr_wl) begin
        win_lo_r <= wd;
      end
      if (wr_pm) begin
        cdiv_r <= wd[`SADC_F_CDIV];
      end
      if (wr_ie) begin
        conv_ie_r <= wd[`SADC_B_CONV_IE];
      end
      busy_r <= busy_nxt;
    end
  end

  // sequencer
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state_r   <= sadc_pkg::SADC_IDLE;
      cnt_r     <= 4'h0;
      sar_r     <= 10'h000;
      sh_r      <= 1'b0;
      chan_r    <= 3'h0;
      restart_r <= 1'b0;
    end else if (abort) begin
      state_r   <= sadc_pkg::SADC_IDLE;  // RL21
      cnt_r     <= 4'h0;
      sh_r      <= 1'b0;
      restart_r <= 1'b0;
    end else begin
      case (state_r)
        sadc_pkg::SADC_IDLE: begin
          if (go) begin
            state_r   <= sadc_pkg::SADC_SAMPLE;
            cnt_r     <= 4'h0;
            sar_r     <= 10'h000;
            sh_r      <= 1'b1;
            chan_r    <= mux_r;  // RL24
            restart_r <= 1'b0;
          end else begin
            restart_r <= restart_r & cont_nxt;  // RL17
          end
        end
        sadc_pkg::SADC_SAMPLE: begin
          if (aclk_tick) begin
            cnt_r <= 4'(cnt_r + 4'h1);
            if (cnt_r == `SADC_SAMPLE_LAST) begin
              state_r <= sadc_pkg::SADC_TRIAL;  // RL8
              sar_r   <= `SADC_SAR_MSB;  // RL4
              sh_r    <= 1'b0;
            end
          end
        end
        sadc_pkg::SADC_TRIAL: begin
          if (aclk_tick) begin
            cnt_r <= 4'(cnt_r + 4'h1);
            if (cnt_r == `SADC_CONV_LAST) begin
              state_r   <= sadc_pkg::SADC_IDLE;
              restart_r <= cont_nxt;  // RL16 RL17
            end else begin
              sar_r <= sar_trial;  // RL4
            end
          end
        end
        default: begin
          state_r <= sadc_pkg::SADC_IDLE;
        end
      endcase
    end
  end

  // results, flags and interrupt request; a done in the clearing cycle wins
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      result_r <= 10'h000;
      eoc_r    <= 1'b0;
      match_r  <= 1'b0;
      qual_r   <= 1'b0;
      irq_r    <= 1'b0;
    end else begin
      if (done) begin
        result_r <= sar_r;  // RL3
        match_r  <= win_match;  // RL19
        qual_r   <= ~qual_en_r | win_match;  // RL12
      end
      eoc_r <= done | (eoc_r & ~eoc_clr);  // RL8
      irq_r <= conv_ie_r & eoc_r & qual_r;  // RL12
    end
  end

  assign WB_ACK_O     = ack_r;
  assign WB_DAT_O     = dat_r;
  assign ANALOG_POWER = pwr_r;
  assign SAMPLE_HOLD  = sh_r;
  assign DAC_CODE     = sar_r;
  assign CHANNEL      = chan_r;
  assign IRQ          = irq_r;

  // checks
  logic [3:0] tk_r;
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      tk_r <= 4'h0;
    end else if (go || state_r == sadc_pkg::SADC_IDLE) begin
      tk_r <= 4'h0;
    end else if (aclk_tick) begin
      tk_r <= 4'(tk_r + 4'h1);
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!ARST_N);

  sequence conv_end_s;
    done;
  endsequence
  sequence flags_up_s;
    eoc_r && !busy_r[*1];
  endsequence

  power_gate_a: assert property (state_r != sadc_pkg::SADC_IDLE |-> pwr_r)  // RL1
    else $error("conversion active without power");
  conv_length_a: assert property (conv_end_s |-> tk_r == 4'hF)  // RL8
    else $error("conversion not 16 converter clocks");
  done_flag_a: assert property (conv_end_s |=> eoc_r)  // RL8
    else $error("done flag not set at conversion end");
  busy_during_a: assert property (state_r != sadc_pkg::SADC_IDLE |-> busy_r)  // RL10
    else $error("busy low during conversion");
  abort_clear_a: assert property (!pwr_nxt |=> !busy_r && state_r == sadc_pkg::SADC_IDLE)  // RL21
    else $error("power off did not abort");
  single_halt_a: assert property (conv_end_s and !cont_nxt |=> flags_up_s ##1 !busy_r)  // RL17
    else $error("single shot did not halt");
  cont_restart_a: assert property (restart_r && mclk_tick && cont_nxt && pwr_nxt
                                   |=> state_r == sadc_pkg::SADC_SAMPLE && busy_r)  // RL16
    else $error("continuous restart missed");
  window_eq_a: assert property (conv_end_s |=> match_r == (outside_r ^ (win_up_r < result_r[9:2])
                                ^ (win_lo_r < result_r[9:2])))  // RL19
    else $error("window match wrong");
  busy_hold_a: assert property (busy_r && wr_c1 && !wd[`SADC_B_BUSY] && pwr_nxt && !done
                                |=> busy_r)  // RL23
    else $error("busy cleared by software write");
  ext_start_a: assert property (ext_fall && ext_en_r && !busy_r && pwr_nxt
                                |=> busy_r ##0 sh_r)  // RL9
    else $error("external edge did not start");

endmodule // sadc_top

// File: verification/sadc_analog_model.sv
// behavioural analog front end: sample-hold and comparator
`timescale 1ns/1ps
module sadc_analog_model #(
  parameter logic [79:0] VALS = '0
) (
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       power,
  input  wire logic       sample_hold,
  input  wire logic [9:0] dac_code,
  input  wire logic [2:0] channel,
  output logic            dac_below
);
  logic [9:0] held_r;
  logic       junk_r;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      held_r <= 10'h000;
      junk_r <= 1'b0;
    end else begin
      junk_r <= ~junk_r;
      if (sample_hold) begin
        held_r <= VALS[channel*10 +: 10];
      end
    end
  end

  // input sits half a step above its code, so a trial equal to the code stays set
  // unpowered comparator output is garbage, so it toggles every cycle
  assign dac_below = power ? (dac_code <= held_r) : junk_r;
endmodule // sadc_analog_model

// File: verification/sadc_top_tb.sv
// self-checking bench for the converter control
`timescale 1ns/1ps
module sadc_top_tb;
  localparam logic [79:0] VALS = {10'h3FF, 10'h155, 10'h2A5, 10'h0AA,
                                  10'h0F0, 10'h07F, 10'h001, 10'h000};
  logic        CLK, ARST_N, WB_CYC_I, WB_STB_I, WB_WE_I, WB_ACK_O, EXT_START;
  logic        COMP_DAC_BELOW, ANALOG_POWER, SAMPLE_HOLD, IRQ;
  logic [31:0] WB_ADR_I, WB_DAT_I, WB_DAT_O;
  logic [3:0]  WB_SEL_I;
  logic [9:0]  DAC_CODE;
  logic [2:0]  CHANNEL;
  logic [31:0] rd;
  int          fails, check_count, sh_cnt, sh_rises;

  sadc_top dut (.CLK(CLK), .ARST_N(ARST_N), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
    .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I),
    .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .EXT_START(EXT_START),
    .COMP_DAC_BELOW(COMP_DAC_BELOW), .ANALOG_POWER(ANALOG_POWER),
    .SAMPLE_HOLD(SAMPLE_HOLD), .DAC_CODE(DAC_CODE), .CHANNEL(CHANNEL), .IRQ(IRQ));

  sadc_analog_model #(.VALS(VALS)) afe (.clk(CLK), .arst_n(ARST_N), .power(ANALOG_POWER),
    .sample_hold(SAMPLE_HOLD), .dac_code(DAC_CODE), .channel(CHANNEL),
    .dac_below(COMP_DAC_BELOW));

  always #2 CLK = ~CLK;

  logic        sh_q = 1'b0;
  always @(posedge CLK) begin
    if (SAMPLE_HOLD === 1'b1) sh_cnt++;
    if (SAMPLE_HOLD === 1'b1 && sh_q !== 1'b1) sh_rises++;
    sh_q = SAMPLE_HOLD;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wb(input logic we, input logic [11:0] adr, input logic [7:0] wd);
    int n;
    n = 0;
    WB_CYC_I <= 1'b1;
    WB_STB_I <= 1'b1;
    WB_WE_I  <= we;
    WB_ADR_I <= {20'h0_0000, adr};
    WB_DAT_I <= {24'h00_0000, wd};
    WB_SEL_I <= 4'h1;
    do begin
      @(posedge CLK);
      n++;
    end while (WB_ACK_O !== 1'b1 && n < 50);
    if (n >= 50) fails++;
    rd = WB_DAT_O;
    WB_CYC_I <= 1'b0;
    WB_STB_I <= 1'b0;
    WB_WE_I  <= 1'b0;
    @(posedge CLK);
  endtask

  // polls control 1 until the done flag shows
  task automatic wait_done();
    int n;
    n = 0;
    do begin
      wb(1'b0, 12'h2C8, 8'h00);
      n++;
    end while (rd[6] !== 1'b1 && n < 8000);
    if (n >= 8000) fails++;
  endtask

  task automatic run_case(input logic [2:0] ch, input logic fmt, input logic [3:0] psc,
                          input logic [1:0] dv, input logic [7:0] up, input logic [7:0] lo,
                          input logic outs, input logic qen);
    logic [9:0] v;
    logic       m;
    int         mdiv;
    v = VALS[ch*10 +: 10];
    m = outs ^ (up < v[9:2]) ^ (lo < v[9:2]);
    mdiv = (dv == 2'h0) ? 4 : (dv == 2'h1) ? 64 : 1024;
    wb(1'b1, 12'h2E0, {6'h00, dv});
    wb(1'b1, 12'h2CC, {fmt, ch, psc});
    wb(1'b1, 12'h2D8, up);
    wb(1'b1, 12'h2DC, lo);
    sh_cnt = 0;
    wb(1'b1, 12'h2C8, {4'h8, qen, 2'b01, outs});
    wb(1'b0, 12'h2C8, 8'h00);
    check(rd & 32'h0000_0080, 32'h0000_0080);
    wait_done();
    check(rd, {24'h00_0000, 4'h4, qen, m, 1'b1, outs});
    check(sh_cnt, 5 * (psc + 1) * mdiv);
    check(CHANNEL, ch);
    check(DAC_CODE, v);
    wb(1'b0, 12'h2D0, 8'h00);
    check(rd, fmt ? {30'h0, v[9:8]} : {24'h00_0000, v[9:2]});
    wb(1'b0, 12'h2D4, 8'h00);
    check(rd, {24'h00_0000, v[7:0]});
    check(IRQ, qen ? m : 1'b1);
    wb(1'b1, 12'h2C8, {4'h0, qen, 2'b01, outs});
    repeat (4) @(posedge CLK);
    check(IRQ, 1'b0);
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    #200_000;
    fails++;
    complete_run();
  end

  initial begin
    CLK = 1'b0;
    ARST_N = 1'b0;
    {WB_CYC_I, WB_STB_I, WB_WE_I} = 3'b000;
    WB_ADR_I = 32'h0000_0000;
    WB_DAT_I = 32'h0000_0000;
    WB_SEL_I = 4'h0;
    EXT_START = 1'b1;
    fails = 0;
    check_count = 0;
    sh_cnt = 0;
    sh_rises = 0;
    repeat (5) @(posedge CLK);
    ARST_N <= 1'b1;
    @(posedge CLK);
    for (int a = 12'h2C8; a <= 12'h2E4; a += 4) begin
      wb(1'b0, a[11:0], 8'h00);
      check(rd, 32'h0000_0000);
    end
    wb(1'b0, 12'h300, 8'h00);
    check(rd, 32'h0000_0000);
    check(ANALOG_POWER, 1'b0);
    wb(1'b1, 12'h2E4, 8'h02);
    wb(1'b1, 12'h2C8, 8'h02);
    repeat (50) @(posedge CLK);
    run_case(3'h5, 1'b0, 4'h0, 2'h0, 8'h80, 8'h20, 1'b0, 1'b0);
    run_case(3'h2, 1'b1, 4'h3, 2'h0, 8'h10, 8'h30, 1'b1, 1'b1);
    run_case(3'h7, 1'b1, 4'h1, 2'h1, 8'h80, 8'h20, 1'b1, 1'b1);
    run_case(3'h0, 1'b0, 4'h0, 2'h2, 8'h00, 8'h00, 1'b0, 1'b0);
    wb(1'b1, 12'h2E0, 8'h00);
    wb(1'b1, 12'h2CC, 8'h00);
    // continuous run, then back to single shot mid-conversion
    wb(1'b1, 12'h2C8, 8'hA2);
    wait_done();
    repeat (10) @(posedge CLK);
    wb(1'b0, 12'h2C8, 8'h00);
    check(rd & 32'h0000_00A0, 32'h0000_00A0);
    wb(1'b1, 12'h2C8, 8'h02);
    wb(1'b0, 12'h2C8, 8'h00);
    check(rd & 32'h0000_0080, 32'h0000_0080);
    wait_done();
    sh_rises = 0;
    repeat (100) @(posedge CLK);
    wb(1'b0, 12'h2C8, 8'h00);
    check(rd & 32'h0000_00E2, 32'h0000_0042);
    check(sh_rises, 0);
    // power drop aborts a running conversion
    wb(1'b1, 12'h2C8, 8'h82);
    repeat (10) @(posedge CLK);
    wb(1'b1, 12'h2C8, 8'h00);
    wb(1'b0, 12'h2C8, 8'h00);
    check(rd & 32'h0000_00C2, 32'h0000_0000);
    check(ANALOG_POWER, 1'b0);
    wb(1'b1, 12'h2C8, 8'h80);
    wb(1'b0, 12'h2C8, 8'h00);
    check(rd & 32'h0000_0080, 32'h0000_0000);
    // pin start, first with the enable off
    wb(1'b1, 12'h2C8, 8'h02);
    repeat (50) @(posedge CLK);
    EXT_START <= 1'b0;
    repeat (10) @(posedge CLK);
    wb(1'b0, 12'h2C8, 8'h00);
    check(rd & 32'h0000_00C0, 32'h0000_0000);
    EXT_START <= 1'b1;
    wb(1'b1, 12'h2C8, 8'h12);
    repeat (5) @(posedge CLK);
    EXT_START <= 1'b0;
    repeat (6) @(posedge CLK);
    check(SAMPLE_HOLD, 1'b1);
    wait_done();
    check(rd & 32'h0000_00C0, 32'h0000_0040);
    EXT_START <= 1'b1;
    complete_run();
  end
endmodule // sadc_top_tb
